// [vdc_pkg.sv]
package vdc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DELAY = 8'h04;
  localparam logic [7:0] ADDR_RINGS = 8'h08;
  localparam logic [7:0] ADDR_BAUD = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] DELAY_RESET = 8'h01;
  localparam logic [7:0] RINGS_RESET = 8'h00;
  localparam logic [15:0] BAUD_RESET = 16'h1458;

  // Timing: send_clear_delay counts in units of 10 ms
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned DELAY_UNIT_MS = 10;
  localparam int unsigned DELAY_UNIT_CYCLES = CLK_HZ / 1000 * DELAY_UNIT_MS;
  localparam logic [7:0] FLASH_TICKS = 8'h19;

  // Option codes
  localparam logic [1:0] FLOW_HW = 2'h3;
  localparam logic [1:0] DTR_IGNORE = 2'h0;
  localparam logic [1:0] DTR_COMMAND = 2'h1;
  localparam logic [1:0] DTR_HANGUP = 2'h2;
  localparam logic [1:0] DTR_RESET = 2'h3;

  // Control register layout
  typedef struct packed {
    logic [18:0] rsvd;
    logic ext_clock_sel;
    logic sync_ready;
    logic test_mode;
    logic offhook;
    logic command_mode;
    logic [1:0] terminal_ready_action;
    logic carrier_forced_setting;
    logic set_ready_select;
    logic send_handshake_select;
    logic [1:0] flow_control_select;
    logic async_sync_select;
  } vdc_ctrl_s;

  // Status register layout
  typedef struct packed {
    logic [23:0] rsvd;
    logic disconnect_seen;
    logic test_error_seen;
    logic ring;
    logic carrier;
    logic set_ready;
    logic send_clear;
    logic send_request;
    logic terminal_ready;
  } vdc_status_s;

  // Modem core to this block
  typedef struct packed {
    logic carrier_present;
    logic ring_on;
    logic test_error;
    logic line_rx_bit;
    logic response_bit;
  } vdc_core_in_s;

  // This block to modem core
  typedef struct packed {
    logic dte_tx_bit;
    logic xmit_edge;
    logic disconnect_pulse;
    logic [1:0] disconnect_code;
    logic hold_connection;
  } vdc_core_out_s;

  // Terminal-facing pins, all active low except data and clocks
  typedef struct packed {
    logic serial_out_line;
    logic send_clear_out;
    logic set_ready_out;
    logic carrier_detect_out;
    logic test_mode_out;
    logic call_alert_out;
    logic xmit_bit_clock;
    logic recv_bit_clock;
    logic auto_answer_lamp;
    logic test_lamp;
    logic terminal_ready_lamp;
    logic offhook_lamp;
  } vdc_pins_s;

  typedef enum logic [1:0] {CS_OFF, CS_WAIT, CS_ON} vdc_clear_e;

endpackage

// [vdc_interchange.sv]
`timescale 1ns/1ps
module vdc_interchange #(
  parameter int unsigned TICK_CYCLES = vdc_pkg::DELAY_UNIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_line,
  input wire logic terminal_ready_in,
  input wire logic send_request_in,
  input wire logic ext_xmit_clock_in,
  input vdc_pkg::vdc_core_in_s core_in,
  output vdc_pkg::vdc_core_out_s core_out,
  output vdc_pkg::vdc_pins_s pins
);

  // Register map, one word per register
  // CTRL [0] sync mode, [2:1] flow select, [3] request handshake
  // CTRL [4] set-ready option, [5] carrier forced, [7:6] ready action
  // CTRL [8] command state, [9] off-hook, [10] test mode
  // CTRL [11] sync data path ready, [12] external transmit clock
  // DELAY [7:0] request-to-clear delay in ticks
  // RINGS [7:0] rings before auto answer, zero turns it off
  // BAUD [15:0] half period of both bit clocks, in pclk cycles
  // STATUS [0] ready in, [1] request in, [2] clear out, [3] set ready
  // STATUS [4] carrier out, [5] ring, [6] test error, [7] disconnect
  // Status bits 6 and 7 clear on a written one; a same-cycle set wins
  // Limits a user must know
  // External clock edges closer than four pclk cycles are lost
  // First delay tick may come early: the delay lasts D-1 to D ticks
  // Reserved control bits read back as zero, whatever was written
  // Reads are captured in the setup cycle, so status is one cycle old

  // Pin synchroniser index
  localparam int SI_DATA = 0;
  localparam int SI_DTR = 1;
  localparam int SI_RTS = 2;
  localparam int SI_XCLK = 3;

  typedef struct packed {
    // Software registers and sticky flags
    vdc_pkg::vdc_ctrl_s ctrl;
    logic [7:0] delay;
    logic [7:0] rings;
    logic [15:0] baud;
    logic disconnect_seen;
    logic test_error_seen;
    // Pin synchroniser: first flop, second flop, delayed copy
    logic [3:0] meta;
    logic [3:0] sync;
    logic [3:0] prev;
    // Request-to-clear delay and the shared time base
    vdc_pkg::vdc_clear_e clear_state;
    logic [7:0] delay_cnt;
    logic [31:0] tick_cnt;
    // Lamp flasher and bit clock divider
    logic [7:0] flash_cnt;
    logic flash;
    logic [15:0] baud_cnt;
    logic bitclk;
    // Registered outputs
    logic [31:0] rdata;
    vdc_pkg::vdc_core_out_s core;
    vdc_pkg::vdc_pins_s pins;
  } vdc_state_s;

  vdc_state_s s;
  vdc_state_s next_s;

  // Decoded levels and strobes
  logic wr;
  logic setup;
  logic mapped;
  logic tick;
  logic dtr_on;
  logic rts_on;
  logic dtr_went_off;
  logic dcd_on;
  logic dsr_on;
  logic link_ready;
  logic clear_on;
  logic bitclk_rise;
  vdc_pkg::vdc_ctrl_s c;
  vdc_pkg::vdc_status_s st;

  // Zero-wait slave; errors flag unmapped addresses
  // Only aligned words at the five offsets are mapped
  always_comb begin
    mapped = 1'b0;
    if (paddr == vdc_pkg::ADDR_CTRL) begin
      mapped = 1'b1;
    end else if (paddr == vdc_pkg::ADDR_DELAY) begin
      mapped = 1'b1;
    end else if (paddr == vdc_pkg::ADDR_RINGS) begin
      mapped = 1'b1;
    end else if (paddr == vdc_pkg::ADDR_BAUD) begin
      mapped = 1'b1;
    end else if (paddr == vdc_pkg::ADDR_STATUS) begin
      mapped = 1'b1;
    end
  end

  // Bus answers and registered outputs
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s.rdata;
  assign core_out = s.core;
  assign pins = s.pins;
  assign wr = psel & penable & pwrite;
  assign setup = psel & ~penable & ~pwrite;

  // Decoded levels from the synchronised pins
  always_comb begin
    c = s.ctrl;
    dtr_on = ~s.sync[SI_DTR];
    rts_on = ~s.sync[SI_RTS];
    dtr_went_off = s.sync[SI_DTR] & ~s.prev[SI_DTR];
    tick = (s.tick_cnt == TICK_CYCLES - 1);
    dcd_on = c.carrier_forced_setting | core_in.carrier_present;
    // option 0 keeps set-ready on; option 1 only when on line
    dsr_on = c.set_ready_select ? (c.offhook & dcd_on) : 1'b1;
    link_ready = dsr_on & dcd_on & c.sync_ready;
    st = '0;
    st.terminal_ready = dtr_on;
    st.send_request = rts_on;
    st.send_clear = ~s.pins.send_clear_out;
    st.set_ready = ~s.pins.set_ready_out;
    st.carrier = ~s.pins.carrier_detect_out;
    st.ring = core_in.ring_on;
    st.test_error_seen = s.test_error_seen;
    st.disconnect_seen = s.disconnect_seen;
  end

  // Next state of the whole block
  always_comb begin
    next_s = s;
    clear_on = 1'b1;
    bitclk_rise = 1'b0;

    // Two flops on every pin before use
    next_s.meta = {ext_xmit_clock_in, send_request_in, terminal_ready_in,
                   serial_in_line};
    next_s.sync = s.meta;
    next_s.prev = s.sync;

    // Time base for delay and flashing
    next_s.tick_cnt = tick ? 32'h0000_0000 : s.tick_cnt + 32'h0000_0001;

    // Register reads are captured in the setup phase
    if (setup) begin
      if (paddr == vdc_pkg::ADDR_CTRL) begin
        next_s.rdata = s.ctrl;
      end else if (paddr == vdc_pkg::ADDR_DELAY) begin
        next_s.rdata = {24'h00_0000, s.delay};
      end else if (paddr == vdc_pkg::ADDR_RINGS) begin
        next_s.rdata = {24'h00_0000, s.rings};
      end else if (paddr == vdc_pkg::ADDR_BAUD) begin
        next_s.rdata = {16'h0000, s.baud};
      end else if (paddr == vdc_pkg::ADDR_STATUS) begin
        next_s.rdata = st;
      end else begin
        next_s.rdata = 32'h0000_0000;
      end
    end

    // Register writes; status bits clear by writing one
    if (wr) begin
      if (paddr == vdc_pkg::ADDR_CTRL) begin
        next_s.ctrl = pwdata;
        next_s.ctrl.rsvd = '0;
      end else if (paddr == vdc_pkg::ADDR_DELAY) begin
        next_s.delay = pwdata[7:0];
      end else if (paddr == vdc_pkg::ADDR_RINGS) begin
        next_s.rings = pwdata[7:0];
      end else if (paddr == vdc_pkg::ADDR_BAUD) begin
        next_s.baud = pwdata[15:0];
      end else if (paddr == vdc_pkg::ADDR_STATUS) begin
        if (pwdata[7]) begin
          next_s.disconnect_seen = 1'b0;
        end
        if (pwdata[6]) begin
          next_s.test_error_seen = 1'b0;
        end
      end
    end

    // Send-clear handshake; sync on-line waits for the data path
    if (!c.async_sync_select) begin
      // request only matters under hardware flow control
      if (c.flow_control_select == vdc_pkg::FLOW_HW && !c.command_mode) begin
        clear_on = rts_on;
      end else begin
        clear_on = 1'b1;
      end
      next_s.clear_state = vdc_pkg::CS_OFF;
    end else if (c.command_mode || !c.offhook) begin
      clear_on = 1'b1;
      next_s.clear_state = vdc_pkg::CS_OFF;
    end else if (!link_ready) begin
      // Off-hook drops clear at once until the link is up
      clear_on = 1'b0;
      next_s.clear_state = vdc_pkg::CS_OFF;
    end else if (!c.send_handshake_select) begin
      clear_on = 1'b1;
    end else begin
      // request on, wait delay ticks, then clear
      clear_on = (s.clear_state == vdc_pkg::CS_ON);
      case (s.clear_state)
        vdc_pkg::CS_OFF: begin
          if (rts_on) begin
            next_s.clear_state = vdc_pkg::CS_WAIT;
            next_s.delay_cnt = s.delay;
          end
        end
        // Counts on the shared tick only
        vdc_pkg::CS_WAIT: begin
          if (!rts_on) begin
            next_s.clear_state = vdc_pkg::CS_OFF;
          end else if (s.delay_cnt == 8'h00) begin
            next_s.clear_state = vdc_pkg::CS_ON;
          end else if (tick) begin
            next_s.delay_cnt = s.delay_cnt - 8'h01;
          end
        end
        default: begin
          if (!rts_on) begin
            next_s.clear_state = vdc_pkg::CS_OFF;
          end
        end
      endcase
    end

    // Terminal-ready off hands the core a disconnect order
    next_s.core.disconnect_pulse = 1'b0;
    next_s.core.hold_connection =
      dtr_on | (c.terminal_ready_action == vdc_pkg::DTR_IGNORE);
    if (dtr_went_off && c.terminal_ready_action != vdc_pkg::DTR_IGNORE) begin
      next_s.core.disconnect_pulse = 1'b1;
      next_s.disconnect_seen = 1'b1;
      // No command escape inside sync data, so hang up instead
      if (c.async_sync_select &&
          c.terminal_ready_action == vdc_pkg::DTR_COMMAND) begin
        next_s.core.disconnect_code = vdc_pkg::DTR_HANGUP;
      end else begin
        next_s.core.disconnect_code = c.terminal_ready_action;
      end
    end

    // Test error latch; set wins over clear, leaving test mode clears
    if (!c.test_mode) begin
      next_s.test_error_seen = 1'b0;
    end
    if (c.test_mode && core_in.test_error) begin
      next_s.test_error_seen = 1'b1;
    end

    // Lamp flash rate derived from the tick
    if (tick) begin
      if (s.flash_cnt >= vdc_pkg::FLASH_TICKS - 8'h01) begin
        next_s.flash_cnt = 8'h00;
        next_s.flash = ~s.flash;
      end else begin
        next_s.flash_cnt = s.flash_cnt + 8'h01;
      end
    end

    // Bit clocks: half-period divider gives exact 50 percent duty
    if (c.async_sync_select) begin
      if (s.baud_cnt >= s.baud - 16'h0001) begin
        next_s.baud_cnt = 16'h0000;
        next_s.bitclk = ~s.bitclk;
        bitclk_rise = ~s.bitclk;
      end else begin
        next_s.baud_cnt = s.baud_cnt + 16'h0001;
      end
    end else begin
      next_s.baud_cnt = 16'h0000;
      next_s.bitclk = 1'b1;
    end

    // External clock edges limited to a quarter of pclk
    // Rising edge: second flop high while the delayed copy is still low
    if (c.async_sync_select && c.ext_clock_sel) begin
      next_s.core.xmit_edge = s.sync[SI_XCLK] & ~s.prev[SI_XCLK];
    end else begin
      next_s.core.xmit_edge = bitclk_rise;
    end

    // Data paths
    // Terminal data reaches the core behind the two sync flops
    next_s.core.dte_tx_bit = s.sync[SI_DATA];
    next_s.pins.serial_out_line =
      c.command_mode ? core_in.response_bit : core_in.line_rx_bit;

    // Pins, low means on except the bit clocks
    next_s.pins.send_clear_out = ~clear_on;
    next_s.pins.set_ready_out = ~dsr_on;
    next_s.pins.carrier_detect_out = ~dcd_on;
    next_s.pins.test_mode_out = ~c.test_mode;
    next_s.pins.call_alert_out = ~core_in.ring_on;
    next_s.pins.xmit_bit_clock = next_s.bitclk;
    next_s.pins.recv_bit_clock = next_s.bitclk;
    next_s.pins.auto_answer_lamp = ~(s.rings != 8'h00);
    next_s.pins.test_lamp = ~(s.test_error_seen & s.flash);
    if (c.terminal_ready_action == vdc_pkg::DTR_IGNORE) begin
      next_s.pins.terminal_ready_lamp = 1'b0;
    end else begin
      next_s.pins.terminal_ready_lamp = s.sync[SI_DTR];
    end
    next_s.pins.offhook_lamp = ~c.offhook;
  end

  // Single state register; reset puts every pin off except send clear, set ready and the terminal ready lamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl <= vdc_pkg::CTRL_RESET;
      s.delay <= vdc_pkg::DELAY_RESET;
      s.rings <= vdc_pkg::RINGS_RESET;
      s.baud <= vdc_pkg::BAUD_RESET;
      // Sync stages idle at the pins' off level, so no false edge
      s.meta <= 4'hf;
      s.sync <= 4'hf;
      s.prev <= 4'hf;
      s.bitclk <= 1'b1;
      // Every pin off except the ones reset shows as on
      s.pins <= '1;
      s.pins.terminal_ready_lamp <= 1'b0;
      s.pins.send_clear_out <= 1'b0;
      s.pins.set_ready_out <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

endmodule

// [vdc_interchange_sva.sv]
`timescale 1ns/1ps
// Port checks; pins settle a few edges after their cause goes quiet
module vdc_interchange_sva #(
  parameter int unsigned TICK_CYCLES = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_in_line,
  input wire logic terminal_ready_in,
  input vdc_pkg::vdc_core_in_s core_in,
  input vdc_pkg::vdc_core_out_s core_out,
  input vdc_pkg::vdc_pins_s pins
);
  // Checks start two edges after reset so reset values are not judged
  logic [1:0] live;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live <= 2'h0;
    end else begin
      live <= {live[0], 1'b1};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !live[1]);
  // Quiet spans long enough to cross the two sync flops
  sequence s_tx_quiet;
    $stable(serial_in_line) [*5];
  endsequence
  sequence s_dtr_on;
    !terminal_ready_in [*6];
  endsequence
  // Both data sources agree, so the mode does not matter
  sequence s_rx_agree;
    (core_in.line_rx_bit == core_in.response_bit &&
      $stable(core_in.line_rx_bit)) [*2];
  endsequence
  AST_TX_FOLLOWS: assert property (
    s_tx_quiet |-> core_out.dte_tx_bit == serial_in_line)
    else $error("terminal data not passed to core");
  AST_RX_PATH: assert property (
    s_rx_agree |-> pins.serial_out_line == core_in.line_rx_bit)
    else $error("received data not on serial out");
  AST_CARRIER_OFF: assert property (
    pins.carrier_detect_out |-> !$past(core_in.carrier_present))
    else $error("carrier shown off while present");
  AST_RING: assert property (
    pins.call_alert_out == !$past(core_in.ring_on))
    else $error("ring indicator wrong");
  AST_TEST_LAMP: assert property (
    pins.test_mode_out [*3] |-> pins.test_lamp)
    else $error("test lamp lit outside test mode");
  AST_DTR_LAMP: assert property (
    s_dtr_on |-> !pins.terminal_ready_lamp)
    else $error("terminal ready lamp off while ready");
  AST_DISC_PULSE: assert property (
    core_out.disconnect_pulse |=> !core_out.disconnect_pulse [*4])
    else $error("disconnect pulse too long");
  AST_XEDGE_PULSE: assert property (
    core_out.xmit_edge |=> !core_out.xmit_edge)
    else $error("transmit edge pulse too long");
endmodule

// [vdc_dte_model.sv]
`timescale 1ns/1ps
// Terminal side: link clock, data line and handshake levels
module vdc_dte_model (
  input wire logic run,
  input wire logic dtr_on,
  input wire logic rts_on,
  input wire logic [7:0] tx_byte,
  input wire logic set_ready_out,
  input wire logic send_clear_out,
  output logic serial_in_line,
  output logic terminal_ready_in,
  output logic send_request_in,
  output logic ext_xmit_clock_in,
  output logic clear_seen
);
  logic [2:0] idx = 3'h0;
  // Handshake pins are active low
  assign terminal_ready_in = !dtr_on;
  assign send_request_in = !rts_on;
  // Clear is heeded only while set-ready is on
  assign clear_seen = !set_ready_out && !send_clear_out;
  // Clock stands high between bursts; phase unrelated to pclk
  initial begin
    ext_xmit_clock_in = 1'b1;
    serial_in_line = 1'b1;
    #7;
    forever begin
      #160;
      ext_xmit_clock_in = run ? !ext_xmit_clock_in : 1'b1;
      serial_in_line = run ? serial_in_line : 1'b1;
      if (run && !ext_xmit_clock_in) begin
        serial_in_line = tx_byte[idx];
        idx = idx + 3'h1;
      end
    end
  end
endmodule

// [v24_dte_interchange_control_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); \
  end end
`define WT(c, m) n = 0; \
  while (!(c) && n < m) begin n++; @(posedge pclk); end \
  if (!(c)) begin mismatches++; $display("CHECK FAILED wait exp 1 got 0"); end
module v24_dte_interchange_control_tb;
  localparam int unsigned TICK = 8;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, run = 1'b0, dtr_on = 1'b0, rts_on = 1'b0;
  logic [7:0] paddr = 8'h0, tx_byte = 8'ha5;
  logic [31:0] pwdata = 32'h0, r = 32'hdefb, prdata, rv;
  logic pready, pslverr, err, p, clear_seen, serial_in_line;
  logic terminal_ready_in, send_request_in, ext_xmit_clock_in;
  logic [1:0] c;
  vdc_pkg::vdc_core_in_s core_in = '0;
  vdc_pkg::vdc_core_out_s core_out;
  vdc_pkg::vdc_pins_s pins;
  int mismatches = 0, checks_done = 0, n, h;
  vdc_interchange #(.TICK_CYCLES(TICK)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_line(serial_in_line),
    .terminal_ready_in(terminal_ready_in),
    .send_request_in(send_request_in),
    .ext_xmit_clock_in(ext_xmit_clock_in), .core_in(core_in),
    .core_out(core_out), .pins(pins));
  vdc_dte_model dte (.run(run), .dtr_on(dtr_on), .rts_on(rts_on),
    .tx_byte(tx_byte), .set_ready_out(pins.set_ready_out),
    .send_clear_out(pins.send_clear_out), .serial_in_line(serial_in_line),
    .terminal_ready_in(terminal_ready_in),
    .send_request_in(send_request_in),
    .ext_xmit_clock_in(ext_xmit_clock_in), .clear_seen(clear_seen));
  // 25 MHz bus clock
  initial begin
    forever #20 pclk = !pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Sync mode reports the command action as a hangup
  function automatic logic [1:0] exp_code(input logic [1:0] a, logic sy);
    return (sy && a == vdc_pkg::DTR_COMMAND) ? vdc_pkg::DTR_HANGUP : a;
  endfunction
  // One APB transfer; waits on pready, the watchdog bounds it
  task automatic apb(input logic [7:0] a, logic w, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wctl(input logic [31:0] d);
    apb(vdc_pkg::ADDR_CTRL, 1'b1, d);
  endtask
  // Pin changes need up to four edges to reach the outputs
  task automatic st;
    repeat (6) @(posedge pclk);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run needs about 1500 cycles
  initial begin
    #400000;
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped word
    apb(vdc_pkg::ADDR_BAUD, 1'b0, 32'h0);
    `CHK("baud", {16'h0, vdc_pkg::BAUD_RESET}, rv)
    apb(vdc_pkg::ADDR_DELAY, 1'b0, 32'h0);
    `CHK("delay", {24'h0, vdc_pkg::DELAY_RESET}, rv)
    apb(8'h14, 1'b1, 32'hffff_ffff);
    `CHK("unmapped wr", 1'b1, err)
    apb(8'h14, 1'b0, 32'h0);
    `CHK("unmapped rd", 32'h0, rv)
    done("registers");
    // Async: request ignored until hardware flow is chosen
    st;
    `CHK("clr async", 1'b0, pins.send_clear_out)
    wctl({29'h0, vdc_pkg::FLOW_HW, 1'b0});
    st;
    `CHK("clr rts off", 1'b1, pins.send_clear_out)
    rts_on <= 1'b1;
    st;
    `CHK("clr rts on", 1'b0, pins.send_clear_out)
    done("async");
    // Sync: off-hook drops clear until the link is up
    apb(vdc_pkg::ADDR_DELAY, 1'b1, 32'h3);
    core_in.carrier_present <= 1'b1;
    rts_on <= 1'b1;
    wctl(32'h209);
    st;
    `CHK("clr offhook", 1'b1, pins.send_clear_out)
    `CHK("carrier", 1'b0, pins.carrier_detect_out)
    `CHK("hook lamp", 1'b0, pins.offhook_lamp)
    wctl(32'ha09);
    `WT(pins.send_clear_out === 1'b0, 100)
    `CHK("clr delay", 1'b1, n >= 2 * TICK + 4 && n <= 3 * TICK + 8)
    `CHK("dte clear", 1'b1, clear_seen)
    rts_on <= 1'b0;
    st;
    `CHK("clr drop", 1'b1, pins.send_clear_out)
    wctl(32'ha01);
    st;
    `CHK("clr ignore", 1'b0, pins.send_clear_out)
    wctl(32'hb09);
    st;
    `CHK("clr command", 1'b0, pins.send_clear_out)
    wctl(32'h219);
    st;
    `CHK("dsr on", 1'b0, pins.set_ready_out)
    core_in.carrier_present <= 1'b0;
    st;
    `CHK("dsr off", 1'b1, pins.set_ready_out)
    done("sync");
    // Bit clocks from a short divider: period ten cycles
    apb(vdc_pkg::ADDR_BAUD, 1'b1, 32'h5);
    wctl(32'h1);
    st;
    h = 0;
    n = 0;
    p = pins.xmit_bit_clock;
    repeat (40) begin
      @(posedge pclk);
      h = h + pins.recv_bit_clock + pins.xmit_bit_clock;
      n = n + (pins.xmit_bit_clock != p);
      p = pins.xmit_bit_clock;
    end
    `CHK("clk toggles", 8, n)
    `CHK("clk high", 40, h)
    // External clock: 100 periods of the link clock
    wctl(32'h1001);
    tx_byte <= r[7:0];
    run <= 1'b1;
    n = 0;
    repeat (800) begin
      @(posedge pclk);
      n = n + core_out.xmit_edge;
    end
    run <= 1'b0;
    `CHK("ext edges", 1'b1, n >= 98 && n <= 102)
    done("clocks");
    // Terminal ready dropped under the command, hangup and reset actions, both modes
    for (int s = 0; s < 2; s++) begin
      for (int a = 1; a < 4; a++) begin
        wctl({24'h0, 2'(a), 5'h0, 1'(s)});
        dtr_on <= 1'b1;
        st;
        `CHK("dtr lamp", 1'b0, pins.terminal_ready_lamp)
        `CHK("hold", 1'b1, core_out.hold_connection)
        dtr_on <= 1'b0;
        c = exp_code(2'(a), 1'(s));
        `WT(core_out.disconnect_pulse === 1'b1, 20)
        `CHK("disc code", c, core_out.disconnect_code)
        st;
        `CHK("dtr lamp off", 1'b1, pins.terminal_ready_lamp)
        `CHK("hold off", 1'b0, core_out.hold_connection)
      end
    end
    wctl(32'h0);
    st;
    `CHK("dtr ignored", 1'b0, pins.terminal_ready_lamp)
    apb(vdc_pkg::ADDR_STATUS, 1'b0, 32'h0);
    `CHK("disc seen", 1'b1, rv[7])
    apb(vdc_pkg::ADDR_STATUS, 1'b1, 32'h80);
    apb(vdc_pkg::ADDR_STATUS, 1'b0, 32'h0);
    `CHK("disc clear", 1'b0, rv[7])
    done("dtr");
    // Random ring counts and data sources, corners first
    for (int i = 0; i < 10; i++) begin
      r = xs(r);
      if (i < 2)
        r[7:0] = (i == 0) ? 8'h00 : 8'hff;
      apb(vdc_pkg::ADDR_RINGS, 1'b1, {24'h0, r[7:0]});
      wctl({23'h0, r[8], 8'h0});
      core_in.line_rx_bit <= r[9];
      core_in.response_bit <= r[10];
      core_in.ring_on <= r[11];
      st;
      `CHK("auto lamp", r[7:0] == 8'h0, pins.auto_answer_lamp)
      `CHK("rx out", r[8] ? r[10] : r[9], pins.serial_out_line)
      `CHK("ring", ~r[11], pins.call_alert_out)
    end
    done("random");
    // Test mode, then an error makes the lamp flash
    wctl(32'h400);
    st;
    `CHK("tm out", 1'b0, pins.test_mode_out)
    `CHK("tm lamp", 1'b1, pins.test_lamp)
    core_in.test_error <= 1'b1;
    @(posedge pclk);
    core_in.test_error <= 1'b0;
    `WT(pins.test_lamp === 1'b0, 400)
    `CHK("tm flash", 1'b1, n < 400)
    wctl(32'h0);
    st;
    `CHK("tm off", 1'b1, pins.test_mode_out)
    done("test");
    end_of_test;
  end
endmodule
bind vdc_interchange vdc_interchange_sva #(.TICK_CYCLES(TICK_CYCLES)) sva (
  .pclk(pclk), .presetn(presetn), .serial_in_line(serial_in_line),
  .terminal_ready_in(terminal_ready_in), .core_in(core_in),
  .core_out(core_out), .pins(pins));
